// File: rtl/switch_ingress_classify_regs.sv
// Ingress classification control registers with the indirect priority-map table.
`timescale 1ns/100ps

// How it works
// - VLAN status bit 0 shows a VLAN table command in progress, self-clearing.
// - Each write to the table command register while no access is pending launches one table access.
// - Command bit 7 picks read (one) or write (zero).
// - Command bits 5:0 index one of 64 entries; bit 6 reserved.
// - Map status bit 0 is set while the access runs, then clears itself.
// - After a read access's pending clears, read data bits 2:0 hold the selected entry priority.
// - Each entry holds a 3-bit priority used for matching ToS/CS values.
// - Table contents are not reset; host writes every entry after power-up.
// - Bit 17 widens listener next headers; bit 16 ignores hop-by-hop next header.
// - Bit 15 makes VLAN rules use the port default VLAN ID.
// - Bit 14 makes the tag priority a queue source.
// - Bit 13 allows monitored packets back to their source port.
// - Bits 12:10 are monitor port map; bits 8 and 7 enable listener/IGMP monitoring.
// - Bit 9 makes the IP TOS/traffic class a queue source.
// - Bit 6 makes clear-on-read counters load 7FFF_FFFCh on read.
// - Bit 5 lets an enabled lookup entry priority override other sources.
// - Bit 4 drops unknown multicast destinations, never broadcast.
// - Bit 3 drops unknown unicast destinations.
// - Bit 2 picks TOS precedence (one) or mapping table (zero) for IPv4.
// - Bit 1 lets tag priority beat IP priority when tag priority enabled.
// - Bit 0 globally enables VLAN ingress rules.
module switch_ingress_classify_regs
  #(
    parameter int ACCESS_CYCLES = ingress_classify_pkg::TABLE_ACCESS_CYCLES,
    parameter int INDEX_WIDTH = 6
  )
  (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Management register port
    input wire ingress_classify_pkg::reg_req_s reg_req_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // VLAN table engine
    input wire logic vlan_cmd_busy_i,
    // Datapath priority lookup
    input wire logic [INDEX_WIDTH-1:0] tos_index_i,
    output logic [2:0] tos_priority_o,
    // Ingress configuration to the switch engine
    output ingress_classify_pkg::ingress_cfg_s ingress_cfg_o
  );
  import ingress_classify_pkg::*;

  localparam int ENTRIES = 1 << INDEX_WIDTH;
  localparam logic [3:0] ACC_LAST = 4'(ACCESS_CYCLES - 1);

  // The four-bit countdown and the five-bit busy helper cap one access at 16 cycles.
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 16 || INDEX_WIDTH != CMD_INDEX_MSB + 1)
  begin
    $error("switch_ingress_classify_regs: unsupported parameter values");
  end

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_num);
    hit = (addr == reg_num);
  endfunction

  logic wr_cmd, wr_wdata, wr_cfg;
  assign wr_cmd = reg_req_i.wr && hit(reg_req_i.addr, PRIORITY_MAP_TABLE_COMMAND_ADDR);
  assign wr_wdata = reg_req_i.wr && hit(reg_req_i.addr, PRIORITY_MAP_WRITE_DATA_ADDR);
  assign wr_cfg = reg_req_i.wr && hit(reg_req_i.addr, GLOBAL_INGRESS_CONFIG_ADDR);

  // Table access control.
  map_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic rnw_q, rnw_d;
  logic [INDEX_WIDTH-1:0] idx_q, idx_d;
  logic [2:0] wdata_q, wdata_d;
  logic [2:0] rdata_q, rdata_d;
  logic access_done;
  logic [2:0] table_q [ENTRIES];

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rnw_d = rnw_q;
    idx_d = idx_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    access_done = 1'b0;
    // Write data changes are refused while busy so a running write is not corrupted.
    if (wr_wdata && state_q == MAP_IDLE)
    begin
      wdata_d = reg_req_i.wdata[PRIO_MSB:0];
    end
    case (state_q)
      MAP_IDLE:
      begin
        if (wr_cmd)
        begin
          rnw_d = reg_req_i.wdata[CMD_RNW_BIT];
          idx_d = reg_req_i.wdata[CMD_INDEX_MSB:0];
          cnt_d = ACC_LAST;
          state_d = MAP_BUSY;
        end
      end
      MAP_BUSY:
      begin
        // Commands arriving now are dropped; the host must wait for pending to clear.
        if (cnt_q == 4'h0)
        begin
          access_done = 1'b1;
          state_d = MAP_IDLE;
          if (rnw_q)
          begin
            rdata_d = table_q[idx_q];
          end
        end
        else
        begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default:
      begin
        state_d = MAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= MAP_IDLE;
      cnt_q <= 4'h0;
      rnw_q <= CMD_RESET[CMD_RNW_BIT];
      idx_q <= CMD_RESET[CMD_INDEX_MSB:0];
      wdata_q <= WRITE_DATA_RESET;
      rdata_q <= READ_DATA_RESET;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rnw_q <= rnw_d;
      idx_q <= idx_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
    end
  end

  // The table has no reset, so software must fill it before priority mapping is used.
  logic [2:0] table_d [ENTRIES];
  always_comb
  begin
    table_d = table_q;
    if (access_done && !rnw_q)
    begin
      table_d[idx_q] = wdata_q;
    end
  end
  always_ff @(posedge core_clk_i)
  begin
    table_q <= table_d;
  end

  // Datapath lookup of the receive priority by ToS/CS value.
  logic [2:0] tos_prio_q, tos_prio_d;
  always_comb
  begin
    tos_prio_d = table_q[tos_index_i];
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tos_prio_q <= 3'h0;
    end
    else
    begin
      tos_prio_q <= tos_prio_d;
    end
  end
  assign tos_priority_o = tos_prio_q;

  // VLAN command pending flag and global configuration.
  logic vlan_pend_q, vlan_pend_d;
  ingress_cfg_s cfg_q, cfg_d;
  always_comb
  begin
    vlan_pend_d = vlan_cmd_busy_i;
    cfg_d = cfg_q;
    if (wr_cfg)
    begin
      cfg_d = ingress_cfg_s'(reg_req_i.wdata[CFG_MSB:0]);
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vlan_pend_q <= 1'b0;
      cfg_q <= ingress_cfg_s'(CFG_RESET);
    end
    else
    begin
      vlan_pend_q <= vlan_pend_d;
      cfg_q <= cfg_d;
    end
  end
  // The engine acts on these fields directly: counter test, overrides and filters.
  assign ingress_cfg_o = cfg_q;

  // Register read path; unmapped register numbers read as zero.
  logic [31:0] rd_q, rd_d;
  logic rvalid_q, rvalid_d;
  always_comb
  begin
    rd_d = 32'h0000_0000;
    rvalid_d = reg_req_i.rd;
    if (reg_req_i.rd)
    begin
      case (reg_req_i.addr)
        VLAN_TABLE_CMD_STATUS_ADDR: rd_d[PENDING_BIT] = vlan_pend_q;
        PRIORITY_MAP_TABLE_COMMAND_ADDR:
        begin
          rd_d[CMD_RNW_BIT] = rnw_q;
          rd_d[CMD_INDEX_MSB:0] = idx_q;
        end
        PRIORITY_MAP_WRITE_DATA_ADDR: rd_d[PRIO_MSB:0] = wdata_q;
        PRIORITY_MAP_READ_DATA_ADDR: rd_d[PRIO_MSB:0] = rdata_q;
        PRIORITY_MAP_CMD_STATUS_ADDR: rd_d[PENDING_BIT] = (state_q == MAP_BUSY);
        GLOBAL_INGRESS_CONFIG_ADDR: rd_d[CFG_MSB:0] = cfg_q;
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rd_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_d;
      rvalid_q <= rvalid_d;
    end
  end
  assign reg_rdata_o = rd_q;
  assign reg_rvalid_o = rvalid_q;

  // Helper: cycles spent busy in the current access.
  logic [4:0] busy_len_q, busy_len_d;
  always_comb
  begin
    busy_len_d = (state_q == MAP_BUSY) ? busy_len_q + 5'h01 : 5'h00;
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy_len_q <= 5'h00;
    end
    else
    begin
      busy_len_q <= busy_len_d;
    end
  end

  a_cmd_launches: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_cmd && state_q == MAP_IDLE) |=> (state_q == MAP_BUSY))
    else $error("table command did not start an access");
  a_cmd_fields: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_cmd && state_q == MAP_IDLE)
      |=> (idx_q == $past(reg_req_i.wdata[5:0]) && rnw_q == $past(reg_req_i.wdata[7])))
    else $error("table command fields not captured");
  a_pend_bounded: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    busy_len_q <= 5'(ACCESS_CYCLES))
    else $error("pending flag held too long");
  a_pend_clears: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(state_q == MAP_BUSY) |-> ##[1:16] (state_q == MAP_IDLE))
    else $error("pending flag never cleared");
  a_read_result: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (access_done && rnw_q) |=> (rdata_q == $past(table_q[idx_q])))
    else $error("read data does not match table entry");
  a_write_stores: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (access_done && !rnw_q) |=> (table_q[$past(idx_q)] == $past(wdata_q)))
    else $error("table write not stored");
  a_busy_ignores: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state_q == MAP_BUSY && cnt_q != 4'h0) |=> $stable(idx_q) && $stable(wdata_q))
    else $error("busy access disturbed");
  a_vlan_flag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    vlan_cmd_busy_i |=> ##1 (reg_rdata_o[0] || !$past(reg_req_i.rd)
      || $past(reg_req_i.addr) != VLAN_TABLE_CMD_STATUS_ADDR))
    else $error("VLAN pending flag not shown");
  a_cfg_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    wr_cfg |=> (ingress_cfg_o.counter_read_test_mode == $past(reg_req_i.wdata[6])
      && ingress_cfg_o.vlan_enable == $past(reg_req_i.wdata[0])))
    else $error("configuration write not applied");
  a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_req_i.rd && reg_req_i.addr == 16'h1815) |=> (reg_rvalid_o && reg_rdata_o == 32'h0))
    else $error("unmapped register did not read zero");

  // Request handling and the read answer.
  a_read_answer: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    reg_req_i.rd |=> reg_rvalid_o)
    else $error("read strobe got no answer");

  a_idle_answer: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !reg_req_i.rd |=> (!reg_rvalid_o && reg_rdata_o == 32'h0000_0000))
    else $error("answer shown without a read strobe");

  a_vlan_follows: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    1'b1 |=> (vlan_pend_q == $past(vlan_cmd_busy_i)))
    else $error("VLAN pending flag does not follow the engine");

  a_vlan_reserved: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_req_i.rd && reg_req_i.addr == VLAN_TABLE_CMD_STATUS_ADDR)
      |=> (reg_rdata_o[31:1] == 31'h0000_0000))
    else $error("VLAN status reserved bits not zero");

  // Table access sequencing.
  a_state_onehot: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $onehot(state_q))
    else $error("table access state is not one-hot");

  a_idle_stays: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state_q == MAP_IDLE && !wr_cmd) |=> (state_q == MAP_IDLE))
    else $error("table access started without a command");

  a_busy_exact: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(state_q == MAP_BUSY) |-> (busy_len_q == 5'(ACCESS_CYCLES)))
    else $error("pending length differs from the access length");

  a_done_once: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    access_done |=> !access_done)
    else $error("one access completed twice");

  a_busy_cmd_dropped: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (state_q == MAP_BUSY && wr_cmd) |=> ($stable(idx_q) && $stable(rnw_q)))
    else $error("command taken while pending");

  a_status_shown: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_req_i.rd && reg_req_i.addr == PRIORITY_MAP_CMD_STATUS_ADDR)
      |=> (reg_rdata_o == {31'h0000_0000, $past(state_q == MAP_BUSY)}))
    else $error("map status register does not show pending");

  // Data registers around the table.
  a_wdata_taken: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_wdata && state_q == MAP_IDLE) |=> (wdata_q == $past(reg_req_i.wdata[2:0])))
    else $error("write data not taken while idle");

  a_wdata_shown: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_req_i.rd && reg_req_i.addr == PRIORITY_MAP_WRITE_DATA_ADDR)
      |=> (reg_rdata_o == {29'h0000_0000, $past(wdata_q)}))
    else $error("write data register read back wrong");

  a_cmd_reserved: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_req_i.rd && reg_req_i.addr == PRIORITY_MAP_TABLE_COMMAND_ADDR)
      |=> (reg_rdata_o[31:8] == 24'h00_0000 && !reg_rdata_o[6]))
    else $error("command register reserved bits not zero");

  a_rdata_held: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !(access_done && rnw_q) |=> $stable(rdata_q))
    else $error("read data changed without a completed read");

  a_rdata_shown: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_req_i.rd && reg_req_i.addr == PRIORITY_MAP_READ_DATA_ADDR)
      |=> (reg_rdata_o == {29'h0000_0000, $past(rdata_q)}))
    else $error("read data register read back wrong");

  // Global configuration.
  a_cfg_held: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !wr_cfg |=> $stable(ingress_cfg_o))
    else $error("configuration changed without a write");

  a_cfg_shown: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_req_i.rd && reg_req_i.addr == GLOBAL_INGRESS_CONFIG_ADDR)
      |=> (reg_rdata_o == {14'h0000, $past(cfg_q)}))
    else $error("configuration register read back wrong");

endmodule

// File: rtl/ingress_classify_pkg.sv
// Package with register numbers, field positions, reset values and types of the ingress block.
package ingress_classify_pkg;

  // Register numbers as seen on the management register port.
  localparam logic [15:0] VLAN_TABLE_CMD_STATUS_ADDR = 16'h1810;
  localparam logic [15:0] PRIORITY_MAP_TABLE_COMMAND_ADDR = 16'h1811;
  localparam logic [15:0] PRIORITY_MAP_WRITE_DATA_ADDR = 16'h1812;
  localparam logic [15:0] PRIORITY_MAP_READ_DATA_ADDR = 16'h1813;
  localparam logic [15:0] PRIORITY_MAP_CMD_STATUS_ADDR = 16'h1814;
  localparam logic [15:0] GLOBAL_INGRESS_CONFIG_ADDR = 16'h1840;

  // Field positions.
  localparam int PENDING_BIT = 0;
  localparam int CMD_RNW_BIT = 7;
  localparam int CMD_INDEX_MSB = 5;
  localparam int PRIO_MSB = 2;
  localparam int CFG_MSB = 17;

  // Reset values.
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [2:0] WRITE_DATA_RESET = 3'h0;
  localparam logic [2:0] READ_DATA_RESET = 3'h0;
  localparam logic [17:0] CFG_RESET = 18'h00006;

  // Cycles that one table access keeps the pending flag set.
  localparam int TABLE_ACCESS_CYCLES = 2;

  // Global ingress configuration, laid out as the register bits 17 down to 0.
  typedef struct packed {
    logic mld_other_next_hdr;
    logic mld_any_hop_next_hdr;
    logic tag_vid_ignore;
    logic tag_priority_enable;
    logic monitor_echo_allow;
    logic [2:0] monitor_port_map;
    logic ip_priority_enable;
    logic mld_monitor_enable;
    logic igmp_monitor_enable;
    logic counter_read_test_mode;
    logic lookup_priority_override;
    logic unknown_mcast_filter;
    logic unknown_ucast_drop;
    logic tos_precedence_select;
    logic tag_over_ip_priority;
    logic vlan_enable;
  } ingress_cfg_s;

  // Management register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    MAP_IDLE = 2'b01,
    MAP_BUSY = 2'b10
  } map_state_e;

endpackage

// File: bench/switch_ingress_classify_regs_test.sv
// Self-checking testbench for the ingress classification register block.
`timescale 1ns/100ps
module switch_ingress_classify_regs_test;
  import ingress_classify_pkg::*;

  logic core_clk_i;
  logic sys_rst_i;
  reg_req_s req;
  logic [31:0] rdata;
  logic rvalid;
  logic vlan_busy;
  logic [5:0] tos_index;
  logic [2:0] tos_prio;
  ingress_cfg_s cfg;
  int mismatches;
  int total_checks;

  switch_ingress_classify_regs switch_ingress_classify_regs_i (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid),
    .vlan_cmd_busy_i(vlan_busy),
    .tos_index_i(tos_index),
    .tos_priority_o(tos_prio),
    .ingress_cfg_o(cfg)
  );

  task automatic check32(input string what, input logic [31:0] expected, input logic [31:0] seen);
    total_checks++;
    if (seen !== expected)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, expected, seen);
    end
  endtask

  task automatic wr_reg(input logic [15:0] addr, input logic [31:0] data);
    @(posedge core_clk_i);
    req.wr <= 1'b1;
    req.addr <= addr;
    req.wdata <= data;
    @(posedge core_clk_i);
    req.wr <= 1'b0;
  endtask

  // The answer is registered, so it is sampled just after the edge that follows the strobe.
  task automatic rd_reg(input logic [15:0] addr, output logic [31:0] data);
    @(posedge core_clk_i);
    req.rd <= 1'b1;
    req.addr <= addr;
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    #1;
    data = rdata;
    check32("read_valid", 32'h1, {31'h0, rvalid});
  endtask

  task automatic table_access(input logic [7:0] cmd);
    logic [31:0] v;
    int busy_cycles;
    busy_cycles = 0;
    wr_reg(PRIORITY_MAP_TABLE_COMMAND_ADDR, {24'h0, cmd});
    // Status is read back to back, one strobe per cycle, so every busy cycle is seen.
    req.rd <= 1'b1;
    req.addr <= PRIORITY_MAP_CMD_STATUS_ADDR;
    v = 32'h1;
    while (v[PENDING_BIT] === 1'b1 && busy_cycles < 20)
    begin
      @(posedge core_clk_i);
      #1;
      v = rdata;
      if (v[PENDING_BIT] === 1'b1)
        busy_cycles++;
    end
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    check32("pending_cycles", TABLE_ACCESS_CYCLES, busy_cycles);
    check32("pending_clear", 32'h0, v);
  endtask

  task automatic test_reset_values();
    logic [31:0] v;
    logic [15:0] zero_regs [4];
    zero_regs = '{VLAN_TABLE_CMD_STATUS_ADDR, PRIORITY_MAP_WRITE_DATA_ADDR,
                  PRIORITY_MAP_READ_DATA_ADDR, PRIORITY_MAP_CMD_STATUS_ADDR};
    check32("cfg_out_reset", 32'h6, {14'h0, cfg});
    rd_reg(GLOBAL_INGRESS_CONFIG_ADDR, v);
    check32("cfg_reset", 32'h6, v);
    foreach (zero_regs[k])
    begin
      rd_reg(zero_regs[k], v);
      check32("zero_reset", 32'h0, v);
    end
  endtask

  task automatic test_unmapped();
    logic [31:0] v;
    wr_reg(16'h1815, 32'hFFFFFFFF);
    rd_reg(16'h1815, v);
    check32("unmapped_read", 32'h0, v);
    rd_reg(GLOBAL_INGRESS_CONFIG_ADDR, v);
    check32("cfg_untouched", 32'h6, v);
  endtask

  task automatic test_config_bits();
    logic [31:0] v;
    logic [31:0] exp;
    for (int i = 0; i < 32; i++)
    begin
      wr_reg(GLOBAL_INGRESS_CONFIG_ADDR, 32'h1 << i);
      rd_reg(GLOBAL_INGRESS_CONFIG_ADDR, v);
      exp = (i < 18) ? (32'h1 << i) : 32'h0;
      check32("cfg_read", exp, v);
      check32("cfg_out", exp, {14'h0, cfg});
    end
  endtask

  task automatic test_table();
    logic [31:0] v;
    wr_reg(PRIORITY_MAP_WRITE_DATA_ADDR, 32'h5);
    table_access(8'h03);
    wr_reg(PRIORITY_MAP_WRITE_DATA_ADDR, 32'hFFFFFFFF);
    rd_reg(PRIORITY_MAP_WRITE_DATA_ADDR, v);
    check32("wdata_width", 32'h7, v);
    // Reserved bit 6 set must not move the access away from entry 63.
    table_access(8'h7F);
    rd_reg(PRIORITY_MAP_TABLE_COMMAND_ADDR, v);
    check32("cmd_readback", 32'h3F, v);
    table_access(8'h83);
    rd_reg(PRIORITY_MAP_READ_DATA_ADDR, v);
    check32("entry_3", 32'h5, v);
    table_access(8'hBF);
    rd_reg(PRIORITY_MAP_READ_DATA_ADDR, v);
    check32("entry_63", 32'h7, v);
    @(posedge core_clk_i);
    tos_index <= 6'h03;
    repeat (2) @(posedge core_clk_i);
    #1;
    check32("lookup_3", 32'h5, {29'h0, tos_prio});
    @(posedge core_clk_i);
    tos_index <= 6'h3F;
    repeat (2) @(posedge core_clk_i);
    #1;
    check32("lookup_63", 32'h7, {29'h0, tos_prio});
  endtask

  task automatic test_overlap();
    logic [31:0] v;
    wr_reg(PRIORITY_MAP_WRITE_DATA_ADDR, 32'h1);
    wr_reg(PRIORITY_MAP_TABLE_COMMAND_ADDR, 32'h0A);
    // This lands while the write above is still pending and must be dropped.
    wr_reg(PRIORITY_MAP_WRITE_DATA_ADDR, 32'h6);
    repeat (4) @(posedge core_clk_i);
    rd_reg(PRIORITY_MAP_WRITE_DATA_ADDR, v);
    check32("wdata_kept", 32'h1, v);
    table_access(8'h8A);
    rd_reg(PRIORITY_MAP_READ_DATA_ADDR, v);
    check32("entry_10", 32'h1, v);
  endtask

  task automatic test_vlan_status();
    logic [31:0] v;
    @(posedge core_clk_i);
    vlan_busy <= 1'b1;
    rd_reg(VLAN_TABLE_CMD_STATUS_ADDR, v);
    check32("vlan_busy", 32'h1, v);
    @(posedge core_clk_i);
    vlan_busy <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rd_reg(VLAN_TABLE_CMD_STATUS_ADDR, v);
    check32("vlan_idle", 32'h0, v);
  endtask

  task automatic test_midrun_reset();
    logic [31:0] v;
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    check32("prio_reset", 32'h0, {29'h0, tos_prio});
    check32("cfg_rereset", 32'h6, {14'h0, cfg});
    sys_rst_i <= 1'b0;
    table_access(8'h83);
    rd_reg(PRIORITY_MAP_READ_DATA_ADDR, v);
    check32("entry_3_kept", 32'h5, v);
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    sys_rst_i = 1'b1;
    req = '0;
    vlan_busy = 1'b0;
    tos_index = 6'h00;
    mismatches = 0;
    total_checks = 0;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    test_reset_values();
    test_unmapped();
    test_config_bits();
    test_table();
    test_overlap();
    test_midrun_reset();
    test_vlan_status();
    tally_and_finish();
  end

  // The whole sequence needs well under a thousand cycles; this allows several times that.
  initial
  begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
endmodule
